// file: pkg/rpc_pkg.sv
// rpc_pkg: constants and types shared by the rating packet command parser
// assumes a 50 MHz system clock and 8-bit received serial characters
package rpc_pkg;

  // character codes of the command frame
  localparam logic [7:0] RPC_CH_LEAD = 8'h01;
  localparam logic [7:0] RPC_CH_ARTICLE = 8'h50;
  localparam logic [7:0] RPC_CH_SPACE = 8'h20;
  localparam logic [7:0] RPC_CH_CR = 8'h0D;
  localparam logic [7:0] RPC_CH_ZERO = 8'h30;
  localparam logic [7:0] RPC_CH_NINE = 8'h39;

  // packet type field and fixed second field, as packed bcd digits
  localparam logic [15:0] RPC_TYPE_FIELD = 16'h0105;
  localparam logic [15:0] RPC_FIXED_FIELD = 16'h9999;

  // rating code ranges of the four systems
  localparam logic [15:0] RPC_MPAA_LO = 16'h4040;
  localparam logic [15:0] RPC_MPAA_HI = 16'h4740;
  localparam logic [15:0] RPC_MPAA_STEP = 16'h0100;
  localparam logic [15:0] RPC_USTV_LO = 16'h4840;
  localparam logic [15:0] RPC_USTV_HI = 16'h4847;
  localparam logic [15:0] RPC_CAEN_LO = 16'h5840;
  localparam logic [15:0] RPC_CAEN_HI = 16'h5846;
  localparam logic [15:0] RPC_CAFR_LO = 16'h7840;
  localparam logic [15:0] RPC_CAFR_HI = 16'h7845;

  // reset defaults of operator settings
  localparam logic [15:0] RPC_RATING_RST = 16'h4040;
  localparam logic [2:0] RPC_BAUD_RST = 3'h0;
  localparam logic RPC_BRIDGE_RST = 1'b0;

  // timing
  localparam int RPC_CLK_HZ = 50000000;
  localparam int RPC_FLUSH_S = 16;
  localparam longint RPC_FLUSH_CYC = longint'(RPC_FLUSH_S) * longint'(RPC_CLK_HZ);

  // fifo defaults
  localparam int RPC_FIFO_W = 8;
  localparam int RPC_FIFO_D = 32;

  // parser states, gray coded along the usual path from idle to the terminator state
  typedef enum logic [3:0] {
    RPC_S_IDLE = 4'h0,
    RPC_S_ART = 4'h1,
    RPC_S_SP1 = 4'h3,
    RPC_S_TYPE = 4'h2,
    RPC_S_SP2 = 4'h6,
    RPC_S_FIX = 4'h7,
    RPC_S_SP3 = 4'h5,
    RPC_S_CODE = 4'h4,
    RPC_S_CR = 4'hC
  } rpc_state_t;

endpackage

// file: verif/rpc_host_model.sv
// rpc_host_model: host computer sending command characters to the parser
// assumes the bench calls its tasks; drives off the falling edge
`timescale 1ns/1ns
module rpc_host_model (
  // clock
  input wire logic clk_i,
  // character stream toward the parser
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  // line idle at start
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'hFF;
  end
  // offer one character and hold it until taken
  task automatic put(input logic [7:0] b);
    @(negedge clk_i);
    rx_valid_o = 1'b1;
    rx_data_o = b;
    while (rx_ready_i !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
  endtask
  // released line shows the inverse of the last character
  task automatic idle();
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o;
  endtask
  // digits of a field, most significant first
  task automatic fld(input logic [15:0] v, input int nd);
    for (int i = nd - 1; i >= 0; i--) put({4'h3, v[i*4+:4]});
  endtask
  // lead-in, article letter, fields and terminator
  task automatic cmd(input logic [15:0] ty, input logic [15:0] code, input int nd,
                     input logic [7:0] term);
    put(8'h01);
    put(8'h50);
    put(8'h20);
    fld(ty, 4);
    put(8'h20);
    fld(16'h9999, 4);
    put(8'h20);
    fld(code, nd);
    put(term);
    idle();
  endtask
endmodule

// file: verif/rpc_parser_assertions.sv
// rpc_parser_assertions: port-level checks of the rating command parser
// assumes one clock domain and one-cycle status pulses
`timescale 1ns/1ns
module rpc_parser_assertions #(
  parameter longint FLUSH_CYC = rpc_pkg::RPC_FLUSH_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // watched inputs
  input wire logic factory_rst_i,
  input wire logic set_baud_i,
  input wire logic [2:0] baud_sel_i,
  input wire logic xds_display_i,
  input wire logic pkt_ready_i,
  // watched outputs
  input wire logic pkt_valid_o,
  input wire logic [15:0] pkt_rating_o,
  input wire logic pkt_local_o,
  input wire logic dec_flush_o,
  input wire logic dec_update_o,
  input wire logic [15:0] cur_rating_o,
  input wire logic cmd_ok_o,
  input wire logic cmd_err_o,
  input wire logic [2:0] baud_sel_o,
  input wire logic bridge_en_o
);
  import rpc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [31:0] gap_q;
  logic seen_q;
  // cycles since the last flush tick while display mode stays on
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else if (!xds_display_i) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else if (dec_flush_o) begin
      gap_q <= '0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  // codes of the four rating systems
  function automatic logic legal(input logic [15:0] c);
    return (c[15:8] inside {[8'h40:8'h47]} && c[7:0] == 8'h40)
      || (c[15:8] == 8'h48 && c[7:0] inside {[8'h40:8'h47]})
      || (c[15:8] == 8'h58 && c[7:0] inside {[8'h40:8'h46]})
      || (c[15:8] == 8'h78 && c[7:0] inside {[8'h40:8'h45]});
  endfunction
  sequence s_pkt_wait;
    pkt_valid_o && !pkt_ready_i && !factory_rst_i;
  endsequence
  property p_pkt_hold;
    s_pkt_wait |=> pkt_valid_o && $stable(pkt_rating_o) && $stable(pkt_local_o);
  endproperty
  property p_err_keep;
    cmd_err_o |-> !cmd_ok_o && !dec_update_o && $stable(cur_rating_o);
  endproperty
  property p_upd_ok;
    dec_update_o == cmd_ok_o;
  endproperty
  property p_upd_pkt;
    dec_update_o |-> pkt_valid_o && !pkt_local_o && pkt_rating_o == cur_rating_o;
  endproperty
  property p_code_legal;
    cmd_ok_o |-> legal(cur_rating_o);
  endproperty
  property p_factory;
    factory_rst_i |=> baud_sel_o == RPC_BAUD_RST && bridge_en_o == RPC_BRIDGE_RST
      && cur_rating_o == RPC_RATING_RST;
  endproperty
  property p_set_baud;
    set_baud_i && !factory_rst_i |=> baud_sel_o == $past(baud_sel_i);
  endproperty
  property p_flush_gap;
    dec_flush_o && seen_q |-> gap_q == FLUSH_CYC - 1;
  endproperty
  property p_flush_bound;
    seen_q |-> gap_q < FLUSH_CYC;
  endproperty
  a_pkt_hold: assert property (p_pkt_hold) else $error("packet changed while waiting");
  a_err_keep: assert property (p_err_keep) else $error("rejected command moved rating");
  a_upd_ok: assert property (p_upd_ok) else $error("update and accept differ");
  a_upd_pkt: assert property (p_upd_pkt) else $error("update without host packet");
  a_code_legal: assert property (p_code_legal) else $error("illegal code taken");
  a_factory: assert property (p_factory) else $error("settings not restored");
  a_set_baud: assert property (p_set_baud) else $error("baud not loaded");
  a_flush_gap: assert property (p_flush_gap) else $error("flush period wrong");
  a_flush_bound: assert property (p_flush_bound) else $error("flush overdue");
endmodule
bind rpc_parser rpc_parser_assertions #(.FLUSH_CYC(FLUSH_CYC)) u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .factory_rst_i(factory_rst_i),
  .set_baud_i(set_baud_i), .baud_sel_i(baud_sel_i), .xds_display_i(xds_display_i),
  .pkt_ready_i(pkt_ready_i), .pkt_valid_o(pkt_valid_o), .pkt_rating_o(pkt_rating_o),
  .pkt_local_o(pkt_local_o), .dec_flush_o(dec_flush_o), .dec_update_o(dec_update_o),
  .cur_rating_o(cur_rating_o), .cmd_ok_o(cmd_ok_o), .cmd_err_o(cmd_err_o),
  .baud_sel_o(baud_sel_o), .bridge_en_o(bridge_en_o)
);

// file: verif/tb_rating_packet_command_parser.sv
// tb_rating_packet_command_parser: self-checking bench of the rating parser
// assumes the host model feeds characters and the bench takes packets
`timescale 1ns/1ns
module tb_rating_packet_command_parser;
  import rpc_pkg::*;
  localparam longint FLUSH = 50;
  logic clk_i, sys_rst_i, rx_valid, rx_ready, fac, loc_en, set_baud, set_br, br_in, xds;
  logic pkt_valid, pkt_ready, pkt_local, flush, upd, ok, err, br_o;
  logic [7:0] rx_data;
  logic [15:0] loc_rate, pkt_rate, cur_rate, got_rate;
  logic [2:0] baud_in, baud_o;
  logic got_local;
  int n_errors, n_tests, n_ok, n_err, n_upd, n_flush, cyc, last_fl, gap, b_ok, b_err, b_upd;
  rpc_parser #(.FLUSH_CYC(FLUSH)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .rx_data_i(rx_data),
    .factory_rst_i(fac), .local_rating_en_i(loc_en), .local_rating_i(loc_rate),
    .set_baud_i(set_baud), .baud_sel_i(baud_in), .set_bridge_i(set_br),
    .bridge_en_i(br_in), .xds_display_i(xds), .pkt_valid_o(pkt_valid),
    .pkt_ready_i(pkt_ready), .pkt_rating_o(pkt_rate), .pkt_local_o(pkt_local),
    .dec_flush_o(flush), .dec_update_o(upd), .cur_rating_o(cur_rate), .cmd_ok_o(ok),
    .cmd_err_o(err), .baud_sel_o(baud_o), .bridge_en_o(br_o));
  rpc_host_model u_host (.clk_i(clk_i), .rx_ready_i(rx_ready), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data));
  // clock of 20 ns
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // count pulses, capture packets, cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (ok === 1'b1) n_ok++;
    if (err === 1'b1) n_err++;
    if (upd === 1'b1) n_upd++;
    if (flush === 1'b1) begin
      gap = cyc - last_fl;
      last_fl = cyc;
      n_flush++;
    end
    if (pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
      got_rate = pkt_rate;
      got_local = pkt_local;
    end
    if (cyc > 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic snap();
    b_ok = n_ok;
    b_err = n_err;
    b_upd = n_upd;
  endtask
  // pulses since snap: accepted, rejected, updates match accepted
  task automatic deltas(input int dok, input int derr);
    chk(16'(n_ok - b_ok), 16'(dok));
    chk(16'(n_err - b_err), 16'(derr));
    chk(16'(n_upd - b_upd), 16'(dok));
  endtask
  task automatic send(input logic [15:0] ty, input logic [15:0] c, input int nd,
                      input logic [7:0] t);
    snap();
    u_host.cmd(ty, c, nd, t);
    repeat (40) @(posedge clk_i);
  endtask
  task automatic t_legal();
    logic [15:0] c[$];
    for (int i = 0; i < 8; i++) c.push_back(16'h4040 + 16'(i) * 16'h0100);
    for (int i = 0; i < 8; i++) c.push_back(16'h4840 + 16'(i));
    for (int i = 0; i < 7; i++) c.push_back(16'h5840 + 16'(i));
    for (int i = 0; i < 6; i++) c.push_back(16'h7840 + 16'(i));
    foreach (c[k]) begin
      send(16'h0105, c[k], 4, 8'h0D);
      deltas(1, 0);
      chk(cur_rate, c[k]);
      chk({got_local, got_rate}, {1'b0, c[k]});
    end
  endtask
  task automatic t_bad();
    logic [15:0] c[$] = '{16'h4041, 16'h4848, 16'h5847, 16'h7846, 16'h4940, 16'h5040};
    foreach (c[k]) begin
      send(16'h0105, c[k], 4, 8'h0D);
      deltas(0, 1);
    end
    send(16'h0106, 16'h4140, 4, 8'h0D);
    deltas(0, 1);
    send(16'h0105, 16'h0414, 3, 8'h0D);
    deltas(0, 1);
    send(16'h0105, 16'h4140, 4, 8'h20);
    deltas(0, 1);
    chk(cur_rate, 16'h7845);
    snap();
    u_host.put(8'h50);
    u_host.put(8'h0D);
    u_host.put(8'h01);
    u_host.put(8'h50);
    u_host.cmd(16'h0105, 16'h4240, 4, 8'h0D);
    repeat (10) @(posedge clk_i);
    deltas(1, 1);
    chk(cur_rate, 16'h4240);
  endtask
  task automatic t_fifo();
    int n;
    @(negedge clk_i) pkt_ready = 1'b0;
    send(16'h0105, 16'h4840, 4, 8'h0D);
    for (n = 0; n < 40; n++) begin
      u_host.put(8'h41);
      #1;
      if (rx_ready !== 1'b1) break;
    end
    u_host.idle();
    chk(16'(n + 1), 16'd32);
    chk({15'h0, pkt_valid}, 16'h1);
    @(negedge clk_i) pkt_ready = 1'b1;
    repeat (40) @(posedge clk_i);
    #1;
    chk({rx_ready, got_rate}, {1'b1, 16'h4840});
    deltas(1, 0);
  endtask
  task automatic t_setup();
    @(negedge clk_i);
    {set_baud, baud_in, set_br, br_in} = {1'b1, 3'h5, 1'b1, 1'b1};
    @(negedge clk_i);
    {set_baud, set_br} = 2'b00;
    chk({12'h0, br_o, baud_o}, 16'h000D);
    fac = 1'b1;
    @(negedge clk_i);
    fac = 1'b0;
    chk({br_o, baud_o, cur_rate}, {4'h0, RPC_RATING_RST});
    loc_rate = 16'h5843;
    loc_en = 1'b1;
    repeat (10) @(posedge clk_i);
    chk({got_local, got_rate}, {1'b1, 16'h5843});
    send(16'h0105, 16'h4841, 4, 8'h0D);
    chk({got_local, got_rate}, {1'b0, 16'h4841});
    @(negedge clk_i) loc_en = 1'b0;
  endtask
  task automatic t_flush();
    int f;
    f = n_flush;
    @(negedge clk_i) xds = 1'b1;
    repeat (3 * FLUSH + 5) @(posedge clk_i);
    chk(16'(n_flush - f), 16'd3);
    chk(16'(gap), 16'(FLUSH));
    @(negedge clk_i) xds = 1'b0;
    f = n_flush;
    repeat (2 * FLUSH) @(posedge clk_i);
    chk(16'(n_flush - f), 16'd0);
  endtask
  task automatic report_and_stop();
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    {sys_rst_i, fac, loc_en, set_baud, set_br, br_in, xds, pkt_ready} = 8'h81;
    {baud_in, loc_rate} = '0;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i) sys_rst_i = 1'b0;
    t_legal();
    t_bad();
    t_fifo();
    t_setup();
    t_flush();
    report_and_stop();
  end
endmodule

// file: verilog/rpc_fifo.sv
// rpc_fifo: synchronous valid/ready fifo for received command characters
// assumes writer and reader share clk_i
`timescale 1ns/1ns
module rpc_fifo #(
  parameter int WIDTH = rpc_pkg::RPC_FIFO_W,
  parameter int DEPTH = rpc_pkg::RPC_FIFO_D
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  import rpc_pkg::*;

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("rpc_fifo: depth must be a power of two of at least 2");
    end
  end

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } rpc_fifo_st_t;

  rpc_fifo_st_t st_q, st_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push, pop, full, empty;

  // honest flags from pointer comparison
  assign empty = st_q.wr == st_q.rd;
  assign full = (st_q.wr[AW] != st_q.rd[AW]) && (st_q.wr[AW-1:0] == st_q.rd[AW-1:0]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;
  assign out_data_o = mem_q[st_q.rd[AW-1:0]];

  // pointer update
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr = st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[st_q.wr[AW-1:0]] <= in_data_i;
    end
  end

endmodule

// file: verilog/rpc_flush_timer.sv
// rpc_flush_timer: periodic pulse generator for the decoder memory flush
// assumes clk_i at the package clock rate
`timescale 1ns/1ns
module rpc_flush_timer #(
  parameter longint PERIOD = rpc_pkg::RPC_FLUSH_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic run_i,
  // one-cycle tick at the end of each period
  output logic tick_o
);
  import rpc_pkg::*;

  initial begin
    if (PERIOD < 2 || PERIOD > 64'h0000_0000_FFFF_FFFF) begin
      $error("rpc_flush_timer: period out of range");
    end
  end

  localparam logic [31:0] LAST = 32'(PERIOD - 1);

  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } rpc_tmr_st_t;

  rpc_tmr_st_t st_q, st_d;

  // count while running, restart when stopped
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!run_i) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == LAST) begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_o = st_q.tick;

endmodule

// file: verilog/rpc_parser.sv
// rpc_parser: serial rating article command interpreter with decoder flush
// assumes received characters arrive from a uart on clk_i as valid/ready
//
// Overview of operation
// RQ1: command is lead-in, P, space, 0105, space, 9999, space, four-char code, CR.
// RQ2: a command starts only on the control-A byte 0x01.
// RQ3: motion-picture codes 4040 through 4740 in steps of 0100 are accepted.
// RQ4: US television codes 4840 through 4847 are accepted.
// RQ5: Canadian English 5840-5846 and Canadian French 7840-7845 are accepted.
// RQ6: in data-service display mode, decoder memory is flushed every 16 seconds.
// RQ7: a packet replacing one of the same type updates the display at once.
// RQ8: a locally configured default rating is inserted when no host supplies one.
// RQ9: factory reset returns baud rate, bridge and other settings to defaults.
// RQ10: malformed or unterminated commands are discarded, rating left unchanged.
`timescale 1ns/1ns
module rpc_parser #(
  parameter longint FLUSH_CYC = rpc_pkg::RPC_FLUSH_CYC,
  parameter int FIFO_DEPTH = rpc_pkg::RPC_FIFO_D
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // received characters from the serial port
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire logic [7:0] rx_data_i,
  // operator settings
  input wire logic factory_rst_i,
  input wire logic local_rating_en_i,
  input wire logic [15:0] local_rating_i,
  input wire logic set_baud_i,
  input wire logic [2:0] baud_sel_i,
  input wire logic set_bridge_i,
  input wire logic bridge_en_i,
  input wire logic xds_display_i,
  // rating packet to the data service inserter
  output logic pkt_valid_o,
  input wire logic pkt_ready_i,
  output logic [15:0] pkt_rating_o,
  output logic pkt_local_o,
  // decoder control and status
  output logic dec_flush_o,
  output logic dec_update_o,
  output logic [15:0] cur_rating_o,
  output logic cmd_ok_o,
  output logic cmd_err_o,
  output logic [2:0] baud_sel_o,
  output logic bridge_en_o
);
  import rpc_pkg::*;

  // refuse sizes that the fifo pointers or the 32-bit flush counter cannot serve
  initial begin
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin
      $error("rpc_parser: fifo depth must be a power of two of at least 2");
    end
    if (FLUSH_CYC < 2 || FLUSH_CYC > 64'h0000_0000_FFFF_FFFF) begin
      $error("rpc_parser: flush period out of range");
    end
  end

  // motion-picture codes step the first byte and keep the second fixed
  function automatic logic in_mpaa(input logic [15:0] c);
    return c >= RPC_MPAA_LO && c <= RPC_MPAA_HI && c[7:0] == RPC_MPAA_LO[7:0];
  endfunction

  // the other systems keep the first byte and step the second
  function automatic logic in_range(input logic [15:0] c, input logic [15:0] lo,
                                    input logic [15:0] hi);
    return c >= lo && c <= hi;
  endfunction

  // accepts one of the four rating systems
  function automatic logic rating_legal(input logic [15:0] c);
    logic ok;
    ok = 1'b0;
    if (in_mpaa(c)) begin
      ok = 1'b1; // see RQ3
    end
    if (in_range(c, RPC_USTV_LO, RPC_USTV_HI)) begin
      ok = 1'b1; // see RQ4
    end
    if (in_range(c, RPC_CAEN_LO, RPC_CAEN_HI) || in_range(c, RPC_CAFR_LO, RPC_CAFR_HI)) begin
      ok = 1'b1; // see RQ5
    end
    return ok;
  endfunction

  // true for an ascii decimal digit
  function automatic logic is_digit(input logic [7:0] ch);
    return ch >= RPC_CH_ZERO && ch <= RPC_CH_NINE;
  endfunction

  typedef struct packed {
    rpc_state_t state;
    logic [1:0] idx;
    logic [15:0] field;
    logic [15:0] rating;
    logic have_host;
    logic pend;
    logic [15:0] out_rating;
    logic out_local;
    logic ok;
    logic err;
    logic update;
    logic [2:0] baud;
    logic bridge;
  } rpc_st_t;

  // reset image: defaults restored, parser idle, nothing pending
  localparam rpc_st_t ST_RST = '{
    state: RPC_S_IDLE,
    idx: 2'h0,
    field: 16'h0000,
    rating: RPC_RATING_RST,
    have_host: 1'b0,
    pend: 1'b0,
    out_rating: RPC_RATING_RST,
    out_local: 1'b0,
    ok: 1'b0,
    err: 1'b0,
    update: 1'b0,
    baud: RPC_BAUD_RST,
    bridge: RPC_BRIDGE_RST
  };

  rpc_st_t st_q, st_d;
  // fifo output toward the parser
  logic f_valid;
  logic f_ready;
  logic [7:0] f_data;
  logic flush_tick;
  logic [7:0] ch;
  logic take;

  // character buffer between the uart and the parser
  rpc_fifo #(
    .WIDTH(RPC_FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(rx_ready_o),
    .in_data_i(rx_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );

  // periodic reacquire while the decoder shows data service
  rpc_flush_timer #(
    .PERIOD(FLUSH_CYC)
  ) u_flush (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(xds_display_i),
    .tick_o(flush_tick)
  );

  // the parser stalls the fifo while a packet waits at the output
  assign f_ready = !st_q.pend;
  assign take = f_valid && f_ready;
  assign ch = f_data;

  // parser, rating store and settings
  always_comb begin
    st_d = st_q;
    st_d.ok = 1'b0;
    st_d.err = 1'b0;
    st_d.update = 1'b0;
    // the inserter takes the waiting packet
    if (st_q.pend && pkt_ready_i) begin
      st_d.pend = 1'b0;
    end
    if (take) begin
      if (ch == RPC_CH_LEAD) begin
        // a lead-in always restarts a frame, abandoning any partial one
        st_d.state = RPC_S_ART; // see RQ2
        if (st_q.state != RPC_S_IDLE) begin
          st_d.err = 1'b1; // see RQ10
        end
      end else begin
        unique case (st_q.state)
          RPC_S_IDLE: begin
            st_d.state = RPC_S_IDLE; // see RQ2
          end
          // the article letter must follow the lead-in
          RPC_S_ART: begin
            st_d.state = (ch == RPC_CH_ARTICLE) ? RPC_S_SP1 : RPC_S_IDLE; // see RQ1
            st_d.err = ch != RPC_CH_ARTICLE;
          end
          // a separator opens the next field
          RPC_S_SP1, RPC_S_SP2, RPC_S_SP3: begin
            st_d.idx = 2'h0;
            st_d.field = '0;
            if (ch != RPC_CH_SPACE) begin
              st_d.state = RPC_S_IDLE; // see RQ10
              st_d.err = 1'b1;
            end else if (st_q.state == RPC_S_SP1) begin
              st_d.state = RPC_S_TYPE;
            end else if (st_q.state == RPC_S_SP2) begin
              st_d.state = RPC_S_FIX;
            end else begin
              st_d.state = RPC_S_CODE;
            end
          end
          RPC_S_TYPE, RPC_S_FIX, RPC_S_CODE: begin
            // four characters per field, shorter fields fail on the digit test
            st_d.field = {st_q.field[11:0], ch[3:0]};
            st_d.idx = st_q.idx + 2'h1;
            if (!is_digit(ch)) begin
              st_d.state = RPC_S_IDLE; // see RQ10
              st_d.err = 1'b1;
            end else if (st_q.idx == 2'h3) begin
              // field complete: on to the next separator, or to the terminator after the code, fixed fields must match
              unique case (st_q.state)
                RPC_S_TYPE: st_d.state = RPC_S_SP2;
                RPC_S_FIX: st_d.state = RPC_S_SP3;
                default: st_d.state = RPC_S_CR;
              endcase
              if (st_q.state == RPC_S_TYPE && st_d.field != RPC_TYPE_FIELD) begin
                st_d.state = RPC_S_IDLE; // see RQ1
                st_d.err = 1'b1;
              end
              if (st_q.state == RPC_S_FIX && st_d.field != RPC_FIXED_FIELD) begin
                st_d.state = RPC_S_IDLE; // see RQ1
                st_d.err = 1'b1;
              end
            end
          end
          RPC_S_CR: begin
            st_d.state = RPC_S_IDLE;
            // only a legal code with its terminator moves the rating
            if (ch == RPC_CH_CR && rating_legal(st_q.field)) begin
              st_d.rating = st_q.field; // see RQ1
              st_d.have_host = 1'b1;
              st_d.ok = 1'b1;
              st_d.update = 1'b1; // see RQ7
              st_d.out_rating = st_q.field;
              st_d.out_local = 1'b0;
              st_d.pend = 1'b1;
            end else begin
              st_d.err = 1'b1; // see RQ10
            end
          end
          // an illegal state code falls back to idle
          default: begin
            st_d.state = RPC_S_IDLE;
          end
        endcase
      end
    end
    // local default rating fills the stream when no host rating was received
    if (!st_d.pend && !st_q.pend && local_rating_en_i && !st_q.have_host
        && rating_legal(local_rating_i)) begin
      st_d.out_rating = local_rating_i; // see RQ8
      st_d.out_local = 1'b1;
      st_d.pend = 1'b1;
    end
    // operator settings
    if (set_baud_i) begin
      st_d.baud = baud_sel_i;
    end
    if (set_bridge_i) begin
      st_d.bridge = bridge_en_i;
    end
    // factory reset drops every operator setting and the host rating
    if (factory_rst_i) begin
      st_d.baud = RPC_BAUD_RST; // see RQ9
      st_d.bridge = RPC_BRIDGE_RST;
      st_d.rating = RPC_RATING_RST;
      st_d.have_host = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // packet toward the inserter
  assign pkt_valid_o = st_q.pend;
  assign pkt_rating_o = st_q.out_rating;
  assign pkt_local_o = st_q.out_local;

  // decoder control
  assign dec_flush_o = flush_tick; // see RQ6
  assign dec_update_o = st_q.update; // see RQ7

  // status and operator settings
  assign cur_rating_o = st_q.rating;
  assign cmd_ok_o = st_q.ok;
  assign cmd_err_o = st_q.err;
  assign baud_sel_o = st_q.baud;
  assign bridge_en_o = st_q.bridge;

endmodule
